// ---- rtl/paging_consts.vh ----
// constants for program paging, data window, ram banks and return stack
`ifndef PAGING_CONSTS_VH
`define PAGING_CONSTS_VH
`define ADDR_WINDOW_BASE 8'hc9
`define ADDR_PAGE_SELECT 8'hca
`define ADDR_BANK_SELECT 8'hcb
`define BANK_LO 8'h00
`define BANK_HI 8'h3f
`define WIN_LO 8'h40
`define WIN_HI 8'h7f
`define GRAM_LO 8'h84
`define GRAM_HI 8'hbf
`define PDATA_LO 8'hc0
`define PDATA_HI 8'hc3
`define PDIR_LO 8'hc4
`define PDIR_HI 8'hc7
`define POPT_LO 8'hcc
`define POPT_HI 8'hcf
`define GRP_DATA 2'h1
`define GRP_DIR 2'h2
`define GRP_OPT 2'h3
`define PC_STATIC_BIT 11
`define STATIC_PAGE 2'h1
`define PAGE_MSB 1
`define WIN_BASE_MSB 6
`define WIN_OFS_W 6
`define BANK1_BIT 3
`define BANK2_BIT 4
`define BANK_NONE 2'h0
`define BANK_ONE 2'h1
`define BANK_TWO 2'h2
`define GRAM_BANK 2'h3
`define STACK_DEPTH 6
`define PC_W 12
`define PMEM_AW 13
`define WO_READ_VALUE 8'h00
`endif

// ---- rtl/return_stack.v ----
// return-address stack, one shift stage per level
`timescale 1ns/10ps
`include "paging_consts.vh"
module return_stack #(
  parameter DEPTH = `STACK_DEPTH,
  parameter WIDTH = `PC_W
) (
  clk,
  rst_b,
  push,
  pop,
  push_data,
  top_reg
);
  input wire clk;
  input wire rst_b;
  input wire push;
  input wire pop;
  input wire [WIDTH-1:0] push_data;
  output wire [WIDTH-1:0] top_reg;

  wire [WIDTH-1:0] level [0:DEPTH];
  assign level[DEPTH] = {WIDTH{1'b0}};
  assign top_reg = level[0];

  // a push past the last level drops the oldest entry
  genvar i;
  generate
    for (i = 0; i < DEPTH; i = i + 1) begin : lvl
      reg [WIDTH-1:0] entry_reg;
      wire [WIDTH-1:0] above;
      if (i == 0) begin : head
        assign above = push_data;
      end else begin : body
        assign above = level[i-1];
      end
      always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
          entry_reg <= {WIDTH{1'b0}};
        end else if (push) begin
          entry_reg <= above;
        end else if (pop) begin
          entry_reg <= level[i+1];
        end
      end
      assign level[i] = entry_reg;
    end
  endgenerate
endmodule

// ---- rtl/program_data_memory_paging.v ----
// program paging, data rom window, ram banks, data decode and stack
//
// Overview of operation
// RL1: page register at cah, write only
// RL2: two page bits pick lower-half page
// RL3: pc bit 11 set forces static page
// RL4: codes 00..11 select pages 0,1,2,3
// RL5: page register has no reset value
// RL6: readout lock blocks external memory readout
// RL7: data 40h-7fh reads program memory bytes
// RL8: window base moves window in 64-byte steps
// RL9: window address is base then low six bits
// RL10: window base at c9h, write only
// RL11: reset leaves window base untouched
// RL12: data 00h-3fh banked, two extra banks
// RL13: six-level twelve-bit return address stack
// RL14: sixty bytes general ram up to bfh
// RL15: port data, direction, option registers decoded
// RL16: window base keeps bits six to zero
// RL17: bank bit 3 bank one, bit 4 two
// RL18: bank register at cbh, write only, uncleared
// RL19: unused bits ignored, registers keep across calls
`timescale 1ns/10ps
`include "paging_consts.vh"
module program_data_memory_paging #(
  parameter STACK_DEPTH = `STACK_DEPTH
) (
  clk,
  rst_b,
  pc,
  prog_mem_addr_reg,
  stk_push,
  stk_pop,
  stk_push_pc,
  stk_top_reg,
  data_addr,
  data_rd,
  data_wr,
  data_wdata,
  data_rdata_reg,
  data_rvalid_reg,
  periph_rd_reg,
  periph_wr_reg,
  periph_grp_reg,
  periph_idx_reg,
  periph_wdata_reg,
  periph_rdata,
  dmem_rd_reg,
  dmem_addr_reg,
  dmem_rdata,
  readout_lock,
  ext_rd_req,
  ext_rd_addr,
  ext_rdata_reg,
  ext_rvalid_reg,
  ext_blocked_reg
);
  input wire clk;
  input wire rst_b;
  input wire [`PC_W-1:0] pc;
  output reg [`PMEM_AW-1:0] prog_mem_addr_reg;
  input wire stk_push;
  input wire stk_pop;
  input wire [`PC_W-1:0] stk_push_pc;
  output wire [`PC_W-1:0] stk_top_reg;
  input wire [7:0] data_addr;
  input wire data_rd;
  input wire data_wr;
  input wire [7:0] data_wdata;
  output reg [7:0] data_rdata_reg;
  output reg data_rvalid_reg;
  output reg periph_rd_reg;
  output reg periph_wr_reg;
  output reg [1:0] periph_grp_reg;
  output reg [1:0] periph_idx_reg;
  output reg [7:0] periph_wdata_reg;
  input wire [7:0] periph_rdata;
  output reg dmem_rd_reg;
  output reg [`PMEM_AW-1:0] dmem_addr_reg;
  input wire [7:0] dmem_rdata;
  input wire readout_lock;
  input wire ext_rd_req;
  input wire [`PMEM_AW-1:0] ext_rd_addr;
  output reg [7:0] ext_rdata_reg;
  output reg ext_rvalid_reg;
  output reg ext_blocked_reg;

  localparam K_NONE = 2'h0;
  localparam K_RAM = 2'h1;
  localparam K_WIN = 2'h2;
  localparam K_PORT = 2'h3;

  // write-only paging registers, deliberately without reset
  reg [`PAGE_MSB:0] page_select_bits_reg;
  reg [`WIN_BASE_MSB:0] window_base_reg;
  reg [1:0] ram_bank_reg;

  reg [7:0] ram [0:255];
  reg [7:0] ram_q_reg;
  reg rd1_reg;
  reg [1:0] rd1_kind_reg;

  reg lock_s1_reg;
  reg lock_s2_reg;
  reg req_s1_reg;
  reg req_s2_reg;
  reg req_s3_reg;
  reg [`PMEM_AW-1:0] ext_a1_reg;
  reg [`PMEM_AW-1:0] ext_a2_reg;
  reg [1:0] xs_reg;

  // external readout engine states
  localparam X_IDLE = 2'h0;
  localparam X_PEND = 2'h1;
  localparam X_FETCH = 2'h2;

  // address decode
  wire in_bank = data_addr <= `BANK_HI;
  wire in_win = (data_addr >= `WIN_LO) && (data_addr <= `WIN_HI);
  wire in_gram = (data_addr >= `GRAM_LO) && (data_addr <= `GRAM_HI);
  wire in_pdata = (data_addr >= `PDATA_LO) && (data_addr <= `PDATA_HI);
  wire in_pdir = (data_addr >= `PDIR_LO) && (data_addr <= `PDIR_HI);
  wire in_popt = (data_addr >= `POPT_LO) && (data_addr <= `POPT_HI);
  wire in_port = in_pdata | in_pdir | in_popt;
  wire in_ram = in_bank | in_gram;

  reg [1:0] port_grp;
  always @* begin
    if (in_pdata) begin
      port_grp = `GRP_DATA;
    end else if (in_pdir) begin
      port_grp = `GRP_DIR;
    end else if (in_popt) begin
      port_grp = `GRP_OPT;
    end else begin
      port_grp = 2'h0;
    end
  end

  // banked region sits in ram slots 0..2, general ram in slot 3
  wire [1:0] ram_slot = in_bank ? ram_bank_reg : `GRAM_BANK; // RL12 RL14
  wire [7:0] ram_idx = {ram_slot, data_addr[`WIN_OFS_W-1:0]};

  reg [1:0] rd_kind;
  always @* begin
    if (in_ram) begin
      rd_kind = K_RAM;
    end else if (in_win) begin
      rd_kind = K_WIN;
    end else if (in_port) begin
      rd_kind = K_PORT;
    end else begin
      rd_kind = K_NONE; // RL1 RL10 RL18
    end
  end

  // one strobe per paging register keeps the decode in one place
  wire wr_page = data_wr && (data_addr == `ADDR_PAGE_SELECT);
  wire wr_window = data_wr && (data_addr == `ADDR_WINDOW_BASE);
  wire wr_bank = data_wr && (data_addr == `ADDR_BANK_SELECT);

  // paging register writes; unused bit positions are dropped
  always @(posedge clk) begin
    if (wr_page) begin
      page_select_bits_reg <= data_wdata[`PAGE_MSB:0]; // RL1 RL2 RL5 RL19
    end
  end

  // no reset: software must rewrite the base before using the window
  always @(posedge clk) begin
    if (wr_window) begin
      window_base_reg <= data_wdata[`WIN_BASE_MSB:0]; // RL8 RL10 RL11 RL16 RL19
    end
  end

  always @(posedge clk) begin
    if (wr_bank) begin
      // both bits set is a software error; bank one wins
      if (data_wdata[`BANK1_BIT]) begin
        ram_bank_reg <= `BANK_ONE; // RL17 RL18
      end else if (data_wdata[`BANK2_BIT]) begin
        ram_bank_reg <= `BANK_TWO; // RL17
      end else begin
        ram_bank_reg <= `BANK_NONE; // RL19
      end
    end
  end

  // ram contents have no reset, like the paging registers
  always @(posedge clk) begin
    if (data_wr && in_ram) begin
      ram[ram_idx] <= data_wdata; // RL12 RL14
    end
  end

  // program fetch mapping, one cycle after pc
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      prog_mem_addr_reg <= 13'h0000;
    end else if (pc[`PC_STATIC_BIT]) begin
      prog_mem_addr_reg <= {`STATIC_PAGE, pc[`PC_STATIC_BIT-1:0]}; // RL3
    end else begin
      prog_mem_addr_reg <= {page_select_bits_reg, pc[`PC_STATIC_BIT-1:0]}; // RL2 RL4
    end
  end

  // data read pipeline, first stage
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rd1_reg <= 1'b0;
      rd1_kind_reg <= K_NONE;
      ram_q_reg <= 8'h00;
      periph_rd_reg <= 1'b0;
      periph_wr_reg <= 1'b0;
      periph_grp_reg <= 2'h0;
      periph_idx_reg <= 2'h0;
      periph_wdata_reg <= 8'h00;
    end else begin
      rd1_reg <= data_rd;
      rd1_kind_reg <= data_rd ? rd_kind : K_NONE;
      if (data_rd && in_ram) begin
        ram_q_reg <= ram[ram_idx];
      end
      periph_rd_reg <= data_rd & in_port; // RL15
      periph_wr_reg <= data_wr & in_port; // RL15
      if ((data_rd | data_wr) && in_port) begin
        periph_grp_reg <= port_grp;
        periph_idx_reg <= data_addr[1:0];
        periph_wdata_reg <= data_wdata;
      end
    end
  end

  // second stage: every data read answers two edges after the request
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      data_rvalid_reg <= 1'b0;
      data_rdata_reg <= 8'h00;
    end else begin
      data_rvalid_reg <= rd1_reg;
      if (rd1_reg) begin
        case (rd1_kind_reg)
          K_RAM: begin
            data_rdata_reg <= ram_q_reg;
          end
          K_WIN: begin
            data_rdata_reg <= dmem_rdata; // RL7
          end
          K_PORT: begin
            data_rdata_reg <= periph_rdata;
          end
          default: begin
            data_rdata_reg <= `WO_READ_VALUE; // RL1 RL10
          end
        endcase
      end
    end
  end

  // option strap and external readout pins are asynchronous
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      lock_s1_reg <= 1'b1;
      lock_s2_reg <= 1'b1;
      req_s1_reg <= 1'b0;
      req_s2_reg <= 1'b0;
      req_s3_reg <= 1'b0;
      ext_a1_reg <= 13'h0000;
      ext_a2_reg <= 13'h0000;
    end else begin
      lock_s1_reg <= readout_lock;
      lock_s2_reg <= lock_s1_reg;
      req_s1_reg <= ext_rd_req;
      req_s2_reg <= req_s1_reg;
      req_s3_reg <= req_s2_reg;
      ext_a1_reg <= ext_rd_addr;
      ext_a2_reg <= ext_a1_reg;
    end
  end

  // the address crosses as a bus; the far side holds it still around the request
  wire ext_rise = req_s2_reg & ~req_s3_reg;
  wire win_now = data_rd & in_win;

  // shared program memory data port; core window reads take priority
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      dmem_rd_reg <= 1'b0;
      dmem_addr_reg <= 13'h0000;
      xs_reg <= X_IDLE;
      ext_rvalid_reg <= 1'b0;
      ext_blocked_reg <= 1'b0;
      ext_rdata_reg <= 8'h00;
    end else begin
      dmem_rd_reg <= win_now;
      ext_rvalid_reg <= 1'b0;
      if (win_now) begin
        dmem_addr_reg <= {window_base_reg, data_addr[`WIN_OFS_W-1:0]}; // RL7 RL9
      end
      // a request arriving while one is answered stays queued: set wins
      case (xs_reg)
        X_IDLE: begin
          if (ext_rise) begin
            xs_reg <= X_PEND;
          end
        end
        X_PEND: begin
          if (win_now) begin
            xs_reg <= X_PEND;
          end else if (lock_s2_reg) begin
            ext_rvalid_reg <= 1'b1;
            ext_blocked_reg <= 1'b1; // RL6
            ext_rdata_reg <= 8'h00; // RL6
            xs_reg <= ext_rise ? X_PEND : X_IDLE;
          end else begin
            dmem_rd_reg <= 1'b1;
            dmem_addr_reg <= ext_a2_reg;
            xs_reg <= X_FETCH;
          end
        end
        X_FETCH: begin
          ext_rvalid_reg <= 1'b1;
          ext_blocked_reg <= 1'b0;
          ext_rdata_reg <= dmem_rdata;
          xs_reg <= ext_rise ? X_PEND : X_IDLE;
        end
        default: begin
          xs_reg <= X_IDLE;
        end
      endcase
    end
  end

  // stack levels hold full twelve-bit pc values
  return_stack #(
    .DEPTH(STACK_DEPTH),
    .WIDTH(`PC_W)
  ) u_stack (
    .clk(clk),
    .rst_b(rst_b),
    .push(stk_push),
    .pop(stk_pop),
    .push_data(stk_push_pc),
    .top_reg(stk_top_reg)
  ); // RL13
endmodule

// ---- testbench/paging_checker_assertions.sv ----
// concurrent checks on the paging block ports
`timescale 1ns/10ps
module paging_checker (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [11:0] pc,
  input wire logic [12:0] prog_mem_addr_reg,
  input wire logic stk_push,
  input wire logic stk_pop,
  input wire logic [11:0] stk_push_pc,
  input wire logic [11:0] stk_top_reg,
  input wire logic [7:0] data_addr,
  input wire logic data_rd,
  input wire logic data_wr,
  input wire logic [7:0] data_wdata,
  input wire logic [7:0] data_rdata_reg,
  input wire logic data_rvalid_reg,
  input wire logic periph_rd_reg,
  input wire logic periph_wr_reg,
  input wire logic [7:0] periph_wdata_reg,
  input wire logic [1:0] periph_grp_reg,
  input wire logic [1:0] periph_idx_reg,
  input wire logic dmem_rd_reg,
  input wire logic [12:0] dmem_addr_reg,
  input wire logic [7:0] dmem_rdata,
  input wire logic [7:0] ext_rdata_reg,
  input wire logic ext_rvalid_reg,
  input wire logic ext_blocked_reg
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  a_static_page: assert property (pc[11] |=> prog_mem_addr_reg[12:11] == 2'h1)
    else $error("static page not forced");
  a_page_write: assert property (data_wr && data_addr == 8'hca ##1 !pc[11] |=>
    prog_mem_addr_reg[12:11] == $past(data_wdata[1:0], 2)) else $error("page code not applied");
  a_read_latency: assert property (data_rd |-> ##2 data_rvalid_reg)
    else $error("read answer late");
  a_window_addr: assert property (data_rd && data_addr[7:6] == 2'h1 |=> dmem_rd_reg &&
    dmem_addr_reg[5:0] == $past(data_addr[5:0])) else $error("window address wrong");
  a_window_data: assert property (data_rd && data_addr[7:6] == 2'h1 ##1 1'b1 |=>
    data_rdata_reg == $past(dmem_rdata)) else $error("window data wrong");
  a_wo_read: assert property (data_rd && data_addr inside {8'hc9, 8'hca, 8'hcb} |->
    ##2 data_rdata_reg == 8'h00) else $error("write-only read not zero");
  a_port_decode: assert property (data_rd && data_addr[7:2] == 6'h30 |=> periph_rd_reg &&
    periph_grp_reg == 2'h1 && periph_idx_reg == $past(data_addr[1:0])) else $error("port decode");
  a_port_write: assert property (data_wr && data_addr[7:2] == 6'h31 |=> periph_wr_reg &&
    periph_grp_reg == 2'h2 && periph_wdata_reg == $past(data_wdata)) else $error("port write");
  a_stack_push: assert property (stk_push |=> stk_top_reg == $past(stk_push_pc))
    else $error("push lost");
  a_pop_restore: assert property (stk_push ##1 (stk_pop && !stk_push) |=>
    stk_top_reg == $past(stk_top_reg, 2)) else $error("pop wrong");
  a_stack_hold: assert property (!stk_push && !stk_pop |=> $stable(stk_top_reg))
    else $error("stack moved");
  a_lock_zero: assert property (ext_rvalid_reg && ext_blocked_reg |-> ext_rdata_reg == 8'h00)
    else $error("locked read leaked");
endmodule
bind program_data_memory_paging paging_checker chk (.*);

// ---- testbench/prog_mem_model.sv ----
// program memory data port and port registers as seen by the block
`timescale 1ns/10ps
module prog_mem_model (
  input wire logic [12:0] dmem_addr_reg,
  input wire logic [1:0] periph_grp_reg,
  input wire logic [1:0] periph_idx_reg,
  output logic [7:0] dmem_rdata,
  output logic [7:0] periph_rdata
);
  // address-dependent bytes so a wrong upper address bit shows up
  assign dmem_rdata = dmem_addr_reg[7:0] ^ {dmem_addr_reg[12:8], 3'h5};
  assign periph_rdata = {periph_grp_reg, periph_idx_reg, 4'ha};
endmodule

// ---- testbench/test_program_data_memory_paging.sv ----
// self-checking bench for program paging, data window, ram banks and stack
`timescale 1ns/10ps
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin bad_count++; \
  $display("[ERR] t=%0t got=%h exp=%h", $time, a, e); end end
module test_program_data_memory_paging;
  logic clk, rst_b, stk_push, stk_pop, data_rd, data_wr, readout_lock, ext_rd_req;
  logic data_rvalid_reg, periph_rd_reg, periph_wr_reg, dmem_rd_reg, ext_rvalid_reg;
  logic ext_blocked_reg;
  logic [11:0] pc, stk_push_pc, stk_top_reg;
  logic [12:0] prog_mem_addr_reg, dmem_addr_reg, ext_rd_addr, ea;
  logic [7:0] data_addr, data_wdata, data_rdata_reg, periph_rdata, dmem_rdata, ext_rdata_reg;
  logic [7:0] periph_wdata_reg, b, got_e, pw;
  logic [1:0] periph_grp_reg, periph_idx_reg;
  logic [7:0] exp_q[$];
  logic [7:0] bv[3];
  logic [11:0] sv[7];
  int bad_count, total_checks;
  program_data_memory_paging dut (.*);
  prog_mem_model mem (.*);
  function automatic logic [7:0] pm(input logic [12:0] a);
    pm = a[7:0] ^ {a[12:8], 3'h5};
  endfunction
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    data_wr = 1'b1;
    data_addr = a;
    data_wdata = d;
    @(negedge clk);
    data_wr = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(negedge clk);
    data_rd = 1'b1;
    data_addr = a;
    exp_q.push_back(e);
    @(negedge clk);
    data_rd = 1'b0;
  endtask
  // request held well past the two-flop sync and the answer
  task automatic ext(input logic [12:0] a, input logic [7:0] e);
    @(negedge clk);
    ext_rd_addr = a;
    ext_rd_req = 1'b1;
    exp_q.push_back(e);
    repeat (10) @(negedge clk);
    ext_rd_req = 1'b0;
    repeat (2) @(negedge clk);
  endtask
  task automatic end_of_test;
    if (bad_count == 0 && total_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk) begin
    if (rst_b && (data_rvalid_reg || ext_rvalid_reg)) begin
      got_e = exp_q.pop_front();
      `CHK(data_rvalid_reg ? data_rdata_reg : ext_rdata_reg, got_e)
    end
  end
  initial begin
    #20000;
    bad_count++;
    end_of_test();
  end
  initial begin
    {stk_push, stk_pop, data_rd, data_wr, readout_lock, ext_rd_req} = '0;
    {pc, stk_push_pc, data_addr, data_wdata, ext_rd_addr} = '0;
    rst_b = 1'b0;
    b = 8'($urandom(32'h53cf_9e0f));
    repeat (4) @(negedge clk);
    rst_b = 1'b1;
    for (int p = 0; p < 4; p++) begin
      pc = 12'($urandom) & 12'h7ff;
      wr(8'hca, {6'($urandom), 2'(p)});
      @(negedge clk);
      `CHK(prog_mem_addr_reg, {2'(p), pc[10:0]})
      pc[11] = 1'b1;
      @(negedge clk);
      `CHK(prog_mem_addr_reg, {2'h1, pc[10:0]})
    end
    // window written before use; bit 7 random to show it is ignored
    for (int i = 0; i < 2; i++) begin
      b = 8'($urandom);
      wr(8'hc9, b);
      rd(8'h40, pm({b[6:0], 6'h00}));
      rd(8'h7f, pm({b[6:0], 6'h3f}));
    end
    for (int i = 0; i < 3; i++) rd(8'hc9 + 8'(i), 8'h00);
    bv = '{8'h08, 8'h10, 8'h00};
    // one bank bit at a time, unused low bits randomised
    for (int i = 0; i < 3; i++) begin
      wr(8'hcb, bv[i] | (8'($urandom) & 8'h07));
      wr(8'h05, 8'h31 + 8'(i));
    end
    wr(8'hbf, 8'h5a);
    for (int i = 0; i < 3; i++) begin
      wr(8'hcb, bv[i]);
      rd(8'h05, 8'h31 + 8'(i));
    end
    rd(8'hbf, 8'h5a);
    rd(8'hc0, 8'h4a);
    rd(8'hc7, 8'hba);
    rd(8'hcf, 8'hfa);
    pw = 8'($urandom);
    wr(8'hc5, pw);
    `CHK({periph_wr_reg, periph_grp_reg, periph_idx_reg}, 5'h19)
    `CHK(periph_wdata_reg, pw)
    for (int i = 0; i < 7; i++) sv[i] = 12'($urandom);
    @(negedge clk);
    stk_push = 1'b1;
    for (int i = 0; i < 7; i++) begin
      stk_push_pc = sv[i];
      @(negedge clk);
    end
    stk_push = 1'b0;
    `CHK(stk_top_reg, sv[6])
    // seventh push dropped the oldest entry
    stk_pop = 1'b1;
    for (int i = 5; i >= 0; i--) begin
      @(negedge clk);
      `CHK(stk_top_reg, (i > 0) ? sv[i] : 12'h000)
    end
    stk_pop = 1'b0;
    rst_b = 1'b0;
    repeat (2) @(negedge clk);
    rst_b = 1'b1;
    rd(8'h7f, pm({b[6:0], 6'h3f}));
    ea = 13'($urandom);
    ext(ea, pm(ea));
    `CHK(ext_blocked_reg, 1'b0)
    ext(13'h1abc, pm(13'h1abc));
    readout_lock = 1'b1;
    repeat (4) @(negedge clk);
    ext(13'h1abc, 8'h00);
    `CHK(ext_blocked_reg, 1'b1)
    repeat (4) @(negedge clk);
    end_of_test();
  end
endmodule
